// *** hdl/power_path_ctrl.sv ***
// Power path switch decision, fault recovery and converter two mode.
// Assumes analog comparator outputs and register bits are synchronous
// to core_clk; register read data is selected by rd_addr each cycle.
`timescale 1ns/100ps
module power_path_ctrl
  import power_path_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    undervoltage_lockout_active,
  input  wire logic                    ac_above_bat,
  input  wire logic                    bus_above_bat,
  input  wire logic                    adapter_overvoltage_flag_cmp,
  input  wire logic                    bus_ovp_cmp,
  input  wire logic                    rail_short_cmp,
  input  wire logic                    bat_overcurrent_cmp,
  input  wire logic                    supplement_cmp,
  input  wire logic                    source_priority_select,
  input  wire logic                    bus_input_suspend,
  input  wire logic                    preregulator_config,
  input  wire logic                    charger_fast_charge,
  input  wire logic                    charger_precharge,
  input  wire logic                    thermistor_present,
  input  wire logic                    sleep_state,
  input  wire logic                    charger_enable,
  input  wire logic [7:0]              rd_addr,
  output logic                         adapter_switch_on_flag,
  output logic                         bus_input_switch_on_flag,
  output logic                         battery_switch_on_flag,
  output power_path_pkg::recovery_t    recovery_sel,
  output power_path_pkg::conv_mode_t   conv_mode,
  output logic                         charger_run,
  output logic [7:0]                   rd_data
);
  import power_path_pkg::*;

  typedef struct packed
  {
    logic       ac_sw;
    logic       bus_sw;
    logic       bat_sw;
    recovery_t  rec;
    conv_mode_t mode;
    logic       chg;
    logic [7:0] rdat;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic adapter_present_flag;
  logic bus_input_present_flag;
  logic rail_low_flag;
  logic batsw_oc_flag;
  logic fault;
  logic bus_usable;
  logic [7:0] sw_stat;
  logic [7:0] det_stat;

  // ****************************************
  // Detection
  // ****************************************
  assign adapter_present_flag   = ac_above_bat & ~adapter_overvoltage_flag_cmp;
  assign bus_input_present_flag = bus_above_bat & ~bus_ovp_cmp;
  assign rail_low_flag          = rail_short_cmp;
  assign batsw_oc_flag          = bat_overcurrent_cmp;
  assign fault                  = rail_low_flag | batsw_oc_flag;
  assign bus_usable             = bus_input_present_flag & ~bus_input_suspend;

  always_comb
  begin
    sw_stat = ZERO_BYTE;
    sw_stat[BAT_SW_BIT] = s_q.bat_sw;
    sw_stat[AC_SW_BIT]  = s_q.ac_sw;
    sw_stat[BUS_SW_BIT] = s_q.bus_sw;
    det_stat = ZERO_BYTE;
    det_stat[RAIL_LOW_BIT] = rail_low_flag;
    det_stat[AC_DET_BIT]   = adapter_present_flag;
    det_stat[BUS_DET_BIT]  = bus_input_present_flag;
    det_stat[ADAPTER_OVERVOLTAGE_FLAG_BIT]   = adapter_overvoltage_flag_cmp;
    det_stat[BUS_OVP_BIT]  = bus_ovp_cmp;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.ac_sw  = 1'b0;
    s_d.bus_sw = 1'b0;
    s_d.bat_sw = 1'b0;
    s_d.rec    = REC_NONE;
    if (undervoltage_lockout_active)
    begin
      s_d.rec = REC_NONE;
    end
    else if (fault)
    begin
      // Switches stay off so the short is not fed; a weak source probes recovery
      if (adapter_present_flag)
        s_d.rec = REC_AC;
      else if (bus_input_present_flag)
        s_d.rec = REC_BUS;
      else
        s_d.rec = REC_ISRC;
    end
    else if (!source_priority_select)
    begin
      s_d.bat_sw = 1'b1;
    end
    else if (adapter_present_flag)
    begin
      s_d.ac_sw  = 1'b1;
      s_d.bat_sw = supplement_cmp;
    end
    else if (bus_usable)
    begin
      s_d.bus_sw = 1'b1;
      s_d.bat_sw = supplement_cmp;
    end
    else
    begin
      s_d.bat_sw = 1'b1;
    end

    // Tracking only in pre-regulator mode while fast charging from an input
    if (preregulator_config && charger_fast_charge && !charger_precharge &&
        thermistor_present && (s_d.ac_sw || s_d.bus_sw))
      s_d.mode = CONV_TRACK;
    else
      s_d.mode = CONV_FIXED;

    s_d.chg = charger_enable; // sleep_state does not gate charging

    if (rd_addr == SWITCH_STATUS_ADDR)
      s_d.rdat = sw_stat;
    else if (rd_addr == DETECT_STATUS_ADDR)
      s_d.rdat = det_stat;
    else
      s_d.rdat = ZERO_BYTE;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s_q.ac_sw  <= 1'b0;
      s_q.bus_sw <= 1'b0;
      s_q.bat_sw <= 1'b0;
      s_q.rec    <= REC_NONE;
      s_q.mode   <= CONV_FIXED;
      s_q.chg    <= 1'b0;
      s_q.rdat   <= ZERO_BYTE;
    end
    else
      s_q <= s_d;
  end

  assign adapter_switch_on_flag   = s_q.ac_sw;
  assign bus_input_switch_on_flag = s_q.bus_sw;
  assign battery_switch_on_flag   = s_q.bat_sw;
  assign recovery_sel             = s_q.rec;
  assign conv_mode                = s_q.mode;
  assign charger_run              = s_q.chg;
  assign rd_data                  = s_q.rdat;

  // ****************************************
  // Assertions
  // ****************************************
  a_undervoltage_lockout_all_off: assert property (@(posedge core_clk) disable iff (!resetn)
    undervoltage_lockout_active |=> !adapter_switch_on_flag && !bus_input_switch_on_flag &&
                    !battery_switch_on_flag && recovery_sel == REC_NONE)
    else $error("switch on during lockout");
  a_fault_off: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && (rail_short_cmp || bat_overcurrent_cmp)) |=>
      !adapter_switch_on_flag && !bus_input_switch_on_flag &&
      !battery_switch_on_flag && recovery_sel != REC_NONE)
    else $error("fault did not open switches");
  a_rec_isrc: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && rail_short_cmp && !(ac_above_bat && !adapter_overvoltage_flag_cmp) &&
     !(bus_above_bat && !bus_ovp_cmp)) |=> recovery_sel == REC_ISRC)
    else $error("wrong recovery source");
  a_adapter_overvoltage_flag_block: assert property (@(posedge core_clk) disable iff (!resetn)
    adapter_overvoltage_flag_cmp |=> !adapter_switch_on_flag)
    else $error("adapter used while overvoltage");
  a_bus_ovp_block: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_ovp_cmp |=> !bus_input_switch_on_flag)
    else $error("bus input used while overvoltage");
  a_prio_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && !rail_short_cmp && !bat_overcurrent_cmp && !source_priority_select)
      |=> battery_switch_on_flag && !adapter_switch_on_flag && !bus_input_switch_on_flag)
    else $error("battery not selected");
  a_suspend_bus: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_input_suspend |=> !bus_input_switch_on_flag)
    else $error("bus switch on while suspended");
  a_supplement: assert property (@(posedge core_clk) disable iff (!resetn)
    adapter_switch_on_flag |-> battery_switch_on_flag == $past(supplement_cmp))
    else $error("supplement mismatch");
  a_no_track_fixed: assert property (@(posedge core_clk) disable iff (!resetn)
    !preregulator_config |=> conv_mode == CONV_FIXED)
    else $error("tracking in stand-alone mode");
  a_status_read: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_addr == SWITCH_STATUS_ADDR |=> rd_data[AC_SW_BIT] == $past(adapter_switch_on_flag))
    else $error("switch status wrong");

  a_ac_detect: assert property (@(posedge core_clk) disable iff (!resetn)
    (ac_above_bat && !adapter_overvoltage_flag_cmp && rd_addr == DETECT_STATUS_ADDR) |=>
      rd_data[AC_DET_BIT])
    else $error("adapter presence not reported");

  a_adapter_overvoltage_flag_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    (adapter_overvoltage_flag_cmp && rd_addr == DETECT_STATUS_ADDR) |=>
      !rd_data[AC_DET_BIT] && rd_data[ADAPTER_OVERVOLTAGE_FLAG_BIT])
    else $error("adapter overvoltage not reported");

  a_bus_detect: assert property (@(posedge core_clk) disable iff (!resetn)
    (bus_above_bat && !bus_ovp_cmp && rd_addr == DETECT_STATUS_ADDR) |=>
      rd_data[BUS_DET_BIT])
    else $error("bus input presence not reported");

  a_bus_ovp_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    (bus_ovp_cmp && rd_addr == DETECT_STATUS_ADDR) |=>
      !rd_data[BUS_DET_BIT] && rd_data[BUS_OVP_BIT])
    else $error("bus input overvoltage not reported");

  a_rail_low_stat: assert property (@(posedge core_clk) disable iff (!resetn)
    (rail_short_cmp && rd_addr == DETECT_STATUS_ADDR) |=>
      rd_data[RAIL_LOW_BIT])
    else $error("rail low not reported");

  a_oc_fault: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && bat_overcurrent_cmp) |=>
      recovery_sel != REC_NONE && !battery_switch_on_flag)
    else $error("overcurrent not treated as fault");

  a_rec_ac: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && fault && adapter_present_flag) |=>
      recovery_sel == REC_AC)
    else $error("adapter resistor not chosen");

  a_rec_bus: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && fault && !adapter_present_flag && bus_input_present_flag) |=>
      recovery_sel == REC_BUS)
    else $error("bus resistor not chosen");

  a_ac_select: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && !fault && source_priority_select && adapter_present_flag) |=>
      adapter_switch_on_flag && !bus_input_switch_on_flag)
    else $error("adapter not selected");

  a_bus_select: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && !fault && source_priority_select && !adapter_present_flag &&
     bus_usable) |=> bus_input_switch_on_flag && !adapter_switch_on_flag)
    else $error("bus input not selected");

  a_bat_fallback: assert property (@(posedge core_clk) disable iff (!resetn)
    (!undervoltage_lockout_active && !fault && source_priority_select && !adapter_present_flag &&
     bus_input_suspend) |=> battery_switch_on_flag && !bus_input_switch_on_flag)
    else $error("battery not used while suspended");

  a_bus_supplement: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_input_switch_on_flag |->
      battery_switch_on_flag == $past(supplement_cmp))
    else $error("bus supplement mismatch");

  a_track_mode: assert property (@(posedge core_clk) disable iff (!resetn)
    (preregulator_config && charger_fast_charge && !charger_precharge &&
     thermistor_present && !undervoltage_lockout_active && !fault && source_priority_select &&
     adapter_present_flag) |=> conv_mode == CONV_TRACK)
    else $error("tracking not selected");

  a_fixed_charge: assert property (@(posedge core_clk) disable iff (!resetn)
    (charger_precharge || !thermistor_present) |=> conv_mode == CONV_FIXED)
    else $error("tracking during precharge");

  a_track_input: assert property (@(posedge core_clk) disable iff (!resetn)
    conv_mode == CONV_TRACK |->
      adapter_switch_on_flag || bus_input_switch_on_flag)
    else $error("tracking on battery");

  a_sleep_charge: assert property (@(posedge core_clk) disable iff (!resetn)
    (charger_enable && sleep_state) |=>
      charger_run)
    else $error("charger held off in sleep");

  a_det_upper: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_addr == DETECT_STATUS_ADDR |=>
      rd_data[7:BUS_OVP_BIT+1] == '0)
    else $error("detect status upper bits set");

  a_unmapped_read: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_addr != SWITCH_STATUS_ADDR && rd_addr != DETECT_STATUS_ADDR) |=>
      rd_data == ZERO_BYTE)
    else $error("unmapped read not zero");

  a_bat_status: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_addr == SWITCH_STATUS_ADDR |=>
      rd_data[BAT_SW_BIT] == $past(battery_switch_on_flag))
    else $error("battery switch status wrong");

  a_bus_status: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_addr == SWITCH_STATUS_ADDR |=>
      rd_data[BUS_SW_BIT] == $past(bus_input_switch_on_flag))
    else $error("bus switch status wrong");
endmodule

// *** hdl/power_path_pkg.sv ***
// Constants for the power path switch controller.
// Assumes comparator flags arrive synchronous to core_clk.
// Operation
// - Adapter present: above margin, no overvoltage
// - Bus input present: above margin, no overvoltage
// - Rail below short threshold raises short flag
// - Battery switch overcurrent raises overcurrent flag
// - Fault forces switches off, enables recovery
// - Recovery: adapter resistor, bus resistor, current source
// - Lockout all off; otherwise priority selection
// - Priority bit zero forces battery only
// - Suspend ignores bus input presence
// - Switch states readable at power_switch_state_status
// - Detection flags readable at input_detect_fault_status
// - Charger allowed to run in sleep
// - Charger fed by converter two pre-regulator
// - Fast charge selects battery tracking mode
// - Battery, precharge, no thermistor: programmed voltage
// - Stand-alone configuration never tracks
package power_path_pkg;
  localparam logic [7:0] SWITCH_STATUS_ADDR = 8'hB9;
  localparam logic [7:0] DETECT_STATUS_ADDR = 8'hBB;
  // Field positions in the switch state status register
  localparam int BAT_SW_BIT  = 0;
  localparam int AC_SW_BIT   = 1;
  localparam int BUS_SW_BIT  = 2;
  // Field positions in the detection status register
  localparam int RAIL_LOW_BIT = 0;
  localparam int AC_DET_BIT   = 1;
  localparam int BUS_DET_BIT  = 2;
  localparam int ADAPTER_OVERVOLTAGE_FLAG_BIT   = 3;
  localparam int BUS_OVP_BIT  = 4;
  localparam int TRACK_OFFSET_MV = 260;
  localparam int HOST_MARGIN_MV  = 250;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0]
  {
    REC_NONE = 3'b000,
    REC_AC   = 3'b001,
    REC_BUS  = 3'b010,
    REC_ISRC = 3'b100
  } recovery_t;

  typedef enum logic [1:0]
  {
    CONV_FIXED = 2'b01,
    CONV_TRACK = 2'b10
  } conv_mode_t;
endpackage

// *** tb/tb_top.sv ***
// Self-checking bench for the power path switch controller.
// Assumes the one-cycle registered answer of the controller; inputs are held
// three cycles before every comparison so the status byte age does not matter.
`timescale 1ns/100ps
module tb_top;
  import power_path_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       undervoltage_lockout_active = 1'b0, ac_above_bat = 1'b0, bus_above_bat = 1'b0;
  logic       adapter_overvoltage_flag_cmp = 1'b0, bus_ovp_cmp = 1'b0, rail_short_cmp = 1'b0;
  logic       bat_overcurrent_cmp = 1'b0, supplement_cmp = 1'b0;
  logic       source_priority_select = 1'b0, bus_input_suspend = 1'b0;
  logic       preregulator_config = 1'b0, charger_fast_charge = 1'b0;
  logic       charger_precharge = 1'b0, thermistor_present = 1'b0;
  logic       sleep_state = 1'b0, charger_enable = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic       adapter_switch_on_flag, bus_input_switch_on_flag, battery_switch_on_flag;
  recovery_t  recovery_sel;
  conv_mode_t conv_mode;
  logic       charger_run;
  logic [7:0] rd_data;
  int         fail_count = 0;
  int         num_checks = 0;

  always #5 core_clk = ~core_clk;

  power_path_ctrl dut (.core_clk(core_clk), .resetn(resetn), .undervoltage_lockout_active(undervoltage_lockout_active),
    .ac_above_bat(ac_above_bat), .bus_above_bat(bus_above_bat), .adapter_overvoltage_flag_cmp(adapter_overvoltage_flag_cmp),
    .bus_ovp_cmp(bus_ovp_cmp), .rail_short_cmp(rail_short_cmp),
    .bat_overcurrent_cmp(bat_overcurrent_cmp), .supplement_cmp(supplement_cmp),
    .source_priority_select(source_priority_select), .bus_input_suspend(bus_input_suspend),
    .preregulator_config(preregulator_config), .charger_fast_charge(charger_fast_charge),
    .charger_precharge(charger_precharge), .thermistor_present(thermistor_present),
    .sleep_state(sleep_state), .charger_enable(charger_enable), .rd_addr(rd_addr),
    .adapter_switch_on_flag(adapter_switch_on_flag),
    .bus_input_switch_on_flag(bus_input_switch_on_flag),
    .battery_switch_on_flag(battery_switch_on_flag), .recovery_sel(recovery_sel),
    .conv_mode(conv_mode), .charger_run(charger_run), .rd_data(rd_data));

  // ****************************************
  // Comparison and model
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_all;
    int acd, bsd, ac, bs, bt, rc, trk, rd;
    acd = ac_above_bat && !adapter_overvoltage_flag_cmp;
    bsd = bus_above_bat && !bus_ovp_cmp;
    ac = 0;
    bs = 0;
    bt = 0;
    rc = 0;
    if (undervoltage_lockout_active)
      rc = 0;
    else if (rail_short_cmp || bat_overcurrent_cmp)
      rc = acd ? 1 : (bsd ? 2 : 4);
    else if (!source_priority_select)
      bt = 1;
    else if (acd)
    begin
      ac = 1;
      bt = supplement_cmp;
    end
    else if (bsd && !bus_input_suspend)
    begin
      bs = 1;
      bt = supplement_cmp;
    end
    else
      bt = 1;
    // Tracking only while an input switch feeds the rail
    // Converter mode is modelled here as trk and checked against conv_mode below
    trk = preregulator_config && (ac || bs) && charger_fast_charge && !charger_precharge
          && thermistor_present;
    if (rd_addr == SWITCH_STATUS_ADDR)
      rd = bs * 4 + ac * 2 + bt;
    else if (rd_addr == DETECT_STATUS_ADDR)
      rd = bus_ovp_cmp * 16 + adapter_overvoltage_flag_cmp * 8 + bsd * 4 + acd * 2 + rail_short_cmp;
    else
      rd = 0;
    chk({5'b0, bus_input_switch_on_flag, adapter_switch_on_flag, battery_switch_on_flag},
        8'(bs * 4 + ac * 2 + bt));
    chk({5'b0, recovery_sel}, 8'(rc));
    chk({6'b0, conv_mode}, trk ? 8'h02 : 8'h01);
    chk({7'b0, charger_run}, {7'b0, charger_enable});
    chk(rd_data, 8'(rd));
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    chk({5'b0, bus_input_switch_on_flag, adapter_switch_on_flag, battery_switch_on_flag},
        8'h00);
    chk({recovery_sel, conv_mode, charger_run, 2'b0}, 8'h08);
    chk(rd_data, 8'h00);
    @(posedge core_clk);
    resetn <= 1'b1;
    $display("reset test done, checks %0d", num_checks);
  endtask

  task automatic random_run(input int n);
    logic [31:0] r, a;
    repeat (n)
    begin
      @(posedge core_clk);
      r = $urandom;
      a = $urandom;
      undervoltage_lockout_active <= r[2:0] == 3'h0;
      rail_short_cmp <= r[5:3] == 3'h0;
      bat_overcurrent_cmp <= r[8:6] == 3'h0;
      {ac_above_bat, bus_above_bat, supplement_cmp, source_priority_select} <= r[12:9];
      adapter_overvoltage_flag_cmp <= r[15:13] == 3'h0;
      bus_ovp_cmp <= r[18:16] == 3'h0;
      {bus_input_suspend, preregulator_config, charger_fast_charge} <= r[21:19];
      {charger_precharge, thermistor_present, sleep_state, charger_enable} <= r[25:22];
      rd_addr <= a[1:0] == 2'h0 ? SWITCH_STATUS_ADDR : a[1:0] == 2'h1 ? DETECT_STATUS_ADDR :
                 a[1:0] == 2'h2 ? 8'hBA : a[15:8];
      repeat (3) @(posedge core_clk);
      #1;
      check_all;
    end
    $display("random test done, checks %0d", num_checks);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'hbf7a));
    do_reset();
    random_run(400);
    do_reset();
    random_run(100);
    summarize();
  end
endmodule
